// >>> rtl/bml_pkg.sv
// constants, modes and states shared by the boot mode select loader
package bml_pkg;

    // ======================================================================
    // clock and timing
    // ======================================================================
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned SYNC_STAGES = 2;
    // cycles after reset release before the synchronised straps are trusted
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    // ======================================================================
    // boot transfer geometry
    // ======================================================================
    localparam int unsigned WORD_W = 48;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [8:0] BOOT_WORDS = 9'h100;
    localparam logic [19:0] BOOT_BASE_ADDR = 20'h40000;
    localparam logic [23:0] BOOT_VECTOR = 24'h040050;
    localparam logic [23:0] RESET_PC = 24'h040004;
    // external memory start address for no-boot execution
    localparam logic [23:0] NOBOOT_PC = 24'h800000;

    // chunk widths and chunks per 48-bit word
    localparam logic [4:0] EPROM_CHUNK_W = 5'h08;
    localparam logic [4:0] HOST8_CHUNK_W = 5'h08;
    localparam logic [4:0] HOST16_CHUNK_W = 5'h10;
    localparam logic [4:0] LINK_CHUNK_W = 5'h04;
    localparam logic [4:0] SPI_CHUNK_W = 5'h10;
    localparam logic [3:0] CHUNKS_8 = 4'h6;
    localparam logic [3:0] CHUNKS_16 = 4'h3;
    localparam logic [3:0] CHUNKS_4 = 4'hc;

    // ======================================================================
    // dma channel and link buffer numbers
    // ======================================================================
    localparam logic [3:0] EXT_DMA_CHANNEL = 4'ha;
    localparam logic [3:0] SPI_DMA_CHANNEL = 4'h8;
    localparam logic [3:0] LINK_DMA_CHANNEL = 4'h4;
    localparam logic [2:0] LINK_BOOT_BUFFER = 3'h4;

    // ======================================================================
    // enumerations
    // ======================================================================
    typedef enum logic [2:0] {
        BML_MODE_NOBOOT = 3'h0,
        BML_MODE_HOST = 3'h1,
        BML_MODE_LINK = 3'h2,
        BML_MODE_SPI = 3'h3,
        BML_MODE_EPROM = 3'h4
    } bml_mode_t;

    typedef enum logic [1:0] {
        BML_ST_STRAP = 2'h0,
        BML_ST_LOAD = 2'h1,
        BML_ST_DONE = 2'h3,
        BML_ST_RUN = 2'h2
    } bml_state_t;

endpackage : bml_pkg

// >>> rtl/bml_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bml_sync #(
    parameter int unsigned W = 1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // ======================================================================
    // first stage is read only by the second
    // ======================================================================
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : bml_sync

// >>> rtl/bml_fifo.sv
// synchronous valid/ready fifo for packed boot words
`timescale 1ns/1ps
module bml_fifo #(
    parameter int unsigned W = 48,
    parameter int unsigned DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    wire empty = (wr_ptr_q == rd_ptr_q);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

    // ======================================================================
    // storage has no reset; only the pointers carry state
    // ======================================================================
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule : bml_fifo

// >>> rtl/bml_loader.sv
// boot mode decoder and power-up boot-load starter
`timescale 1ns/1ps
module bml_loader (
    input wire logic mclk_i,
    input wire logic nrst_i,
    // strap and select pins
    input wire logic eprom_boot_strap_i,
    input wire logic link_boot_strap_i,
    input wire logic host_bus16_i,
    input wire logic boot_memory_select_n_i,
    output logic boot_memory_select_n_o,
    output logic boot_memory_select_oe_o,
    input wire logic bus_owner_i,
    input wire logic select_tristate_i,
    // external port data (eprom bytes or host bytes/halfwords)
    input wire logic [15:0] ext_data_i,
    input wire logic ext_valid_i,
    output logic ext_ready_o,
    // link port nibbles
    input wire logic [3:0] link_data_i,
    input wire logic link_valid_i,
    output logic link_ready_o,
    // spi receive buffer words
    input wire logic [15:0] spi_receive_buffer_i,
    input wire logic spi_rx_valid_i,
    output logic spi_rx_ready_o,
    // internal memory write port
    output logic mem_wr_o,
    output logic [19:0] mem_addr_o,
    output logic [47:0] mem_data_o,
    input wire logic mem_ready_i,
    // status
    output logic [2:0] boot_mode_o,
    output logic mode_valid_o,
    output logic [3:0] dma_channel_o,
    output logic [2:0] link_buffer_o,
    output logic [8:0] dma_count_o,
    output logic dma_active_o,
    output logic external_port_dma_done_irq_o,
    output logic exec_start_o,
    output logic [23:0] exec_pc_o
);

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    logic [3:0] pins_sync;

    bml_sync #(
        .W(4)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .async_i({host_bus16_i, boot_memory_select_n_i, link_boot_strap_i, eprom_boot_strap_i}),
        .sync_o(pins_sync)
    );

    wire eprom_strap_s = pins_sync[0];
    wire link_strap_s = pins_sync[1];
    wire select_pin_s = pins_sync[2];
    wire h16_s = pins_sync[3];

    // ======================================================================
    // mode decode from the synchronised straps
    // ======================================================================
    bml_pkg::bml_mode_t mode_d;
    bml_pkg::bml_mode_t mode_q;
    logic host16_q;

    // eprom strap overrides everything else
    assign mode_d = eprom_strap_s ? bml_pkg::BML_MODE_EPROM :
                    (!link_strap_s && select_pin_s) ? bml_pkg::BML_MODE_HOST :
                    (link_strap_s && select_pin_s) ? bml_pkg::BML_MODE_LINK :
                    link_strap_s ? bml_pkg::BML_MODE_SPI :
                    bml_pkg::BML_MODE_NOBOOT;

    // ======================================================================
    // sequencer
    // ======================================================================
    bml_pkg::bml_state_t state_q;
    bml_pkg::bml_state_t state_d;
    logic [1:0] settle_q;
    logic [8:0] wr_count_q;
    logic irq_q;
    logic exec_q;
    logic [23:0] pc_q;
    logic mode_valid_q;

    wire settled = (settle_q == bml_pkg::STRAP_SETTLE_CYC);
    wire is_noboot = (mode_d == bml_pkg::BML_MODE_NOBOOT);
    wire mem_accept = mem_wr_o && mem_ready_i;
    wire last_word = mem_accept && (wr_count_q == bml_pkg::BOOT_WORDS - 9'h001);

    always_comb begin
        state_d = state_q;
        case (state_q)
            bml_pkg::BML_ST_STRAP: begin
                if (settled) begin
                    state_d = is_noboot ? bml_pkg::BML_ST_RUN : bml_pkg::BML_ST_LOAD;
                end
            end
            bml_pkg::BML_ST_LOAD: begin
                if (last_word) begin
                    state_d = bml_pkg::BML_ST_DONE;
                end
            end
            bml_pkg::BML_ST_DONE: begin
                state_d = bml_pkg::BML_ST_RUN;
            end
            default: begin
                state_d = bml_pkg::BML_ST_RUN;
            end
        endcase
    end

    // straps are caught once, a few cycles after release, then frozen
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_q <= '0;
            mode_q <= bml_pkg::BML_MODE_NOBOOT;
            host16_q <= 1'b0;
            mode_valid_q <= 1'b0;
        end else if (state_q == bml_pkg::BML_ST_STRAP) begin
            settle_q <= settled ? settle_q : settle_q + 2'h1;
            if (settled) begin
                mode_q <= mode_d;
                host16_q <= h16_s;
                mode_valid_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= bml_pkg::BML_ST_STRAP;
        end else begin
            state_q <= state_d;
        end
    end

    // completion: one-cycle interrupt and jump to the vector; no-boot jumps straight out
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_q <= 1'b0;
            exec_q <= 1'b0;
            pc_q <= bml_pkg::RESET_PC;
        end else begin
            irq_q <= last_word;
            exec_q <= last_word || (state_q == bml_pkg::BML_ST_STRAP && settled && is_noboot);
            if (last_word) begin
                pc_q <= bml_pkg::BOOT_VECTOR;
            end else if (state_q == bml_pkg::BML_ST_STRAP && settled && is_noboot) begin
                pc_q <= bml_pkg::NOBOOT_PC;
            end
        end
    end

    // ======================================================================
    // dma arming per mode
    // ======================================================================
    wire loading = (state_q == bml_pkg::BML_ST_LOAD);
    wire m_eprom = (mode_q == bml_pkg::BML_MODE_EPROM);
    wire m_host = (mode_q == bml_pkg::BML_MODE_HOST);
    wire m_link = (mode_q == bml_pkg::BML_MODE_LINK);
    wire m_spi = (mode_q == bml_pkg::BML_MODE_SPI);

    // channel and chunk layout follow the latched mode
    wire [3:0] channel = m_spi ? bml_pkg::SPI_DMA_CHANNEL :
                         m_link ? bml_pkg::LINK_DMA_CHANNEL :
                         bml_pkg::EXT_DMA_CHANNEL;
    wire [4:0] chunk_w = m_eprom ? bml_pkg::EPROM_CHUNK_W :
                         m_link ? bml_pkg::LINK_CHUNK_W :
                         m_spi ? bml_pkg::SPI_CHUNK_W :
                         host16_q ? bml_pkg::HOST16_CHUNK_W : bml_pkg::HOST8_CHUNK_W;
    wire [3:0] chunks = (chunk_w == bml_pkg::LINK_CHUNK_W) ? bml_pkg::CHUNKS_4 :
                        (chunk_w == bml_pkg::HOST16_CHUNK_W) ? bml_pkg::CHUNKS_16 : bml_pkg::CHUNKS_8;

    // ======================================================================
    // source select and packer, least significant chunk first
    // ======================================================================
    logic [47:0] pack_q;
    logic [3:0] chunk_cnt_q;
    logic full_q;
    logic [8:0] packed_q;
    logic fifo_in_ready;

    // eprom uses the low byte lane, host 8-bit also low byte
    wire [15:0] src_data = m_link ? {12'h000, link_data_i} :
                           m_spi ? spi_receive_buffer_i :
                           (chunk_w == bml_pkg::HOST16_CHUNK_W) ? ext_data_i : {8'h00, ext_data_i[7:0]};
    wire src_valid = m_link ? link_valid_i : m_spi ? spi_rx_valid_i : (m_eprom || m_host) && ext_valid_i;
    // stop taking data once every word of the kernel has been packed
    wire take_ok = loading && !full_q && (packed_q != bml_pkg::BOOT_WORDS);
    wire take = take_ok && src_valid;
    // six bits: a nibble offset reaches 44, which a five-bit product would wrap
    wire [5:0] shift_amt = 6'(chunk_cnt_q) * 6'(chunk_w);
    wire [47:0] chunk_shifted = {32'h0, src_data} << shift_amt;
    wire last_chunk = (chunk_cnt_q == chunks - 4'h1);
    wire push = full_q && fifo_in_ready;

    assign ext_ready_o = take_ok && (m_eprom || m_host);
    assign link_ready_o = take_ok && m_link;
    assign spi_rx_ready_o = take_ok && m_spi;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pack_q <= '0;
            chunk_cnt_q <= '0;
            full_q <= 1'b0;
            packed_q <= '0;
        end else begin
            if (take) begin
                pack_q <= (chunk_cnt_q == 4'h0) ? chunk_shifted : (pack_q | chunk_shifted);
                chunk_cnt_q <= last_chunk ? 4'h0 : chunk_cnt_q + 4'h1;
                full_q <= last_chunk;
            end else if (push) begin
                full_q <= 1'b0;
            end
            if (take && last_chunk) begin
                packed_q <= packed_q + 9'h001;
            end
        end
    end

    // ======================================================================
    // word fifo; memory back-pressure reaches the sources through it
    // ======================================================================
    logic fifo_out_valid;
    logic [47:0] fifo_out_data;
    wire mem_free = !mem_wr_o || mem_ready_i;
    // count including a write accepted this cycle, so back-to-back words step the address
    wire [8:0] wr_count_d = wr_count_q + {8'h00, mem_accept};
    wire fifo_pop = loading && mem_free && fifo_out_valid;

    bml_fifo #(
        .W(bml_pkg::WORD_W),
        .DEPTH(bml_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_valid_i(full_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pack_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(loading && mem_free),
        .out_data_o(fifo_out_data)
    );

    // ======================================================================
    // internal memory writer: 256 words from the base address upward
    // ======================================================================
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_wr_o <= 1'b0;
            mem_addr_o <= bml_pkg::BOOT_BASE_ADDR;
            mem_data_o <= '0;
            wr_count_q <= '0;
        end else begin
            if (fifo_pop) begin
                mem_wr_o <= 1'b1;
                mem_data_o <= fifo_out_data;
                mem_addr_o <= bml_pkg::BOOT_BASE_ADDR + {11'h000, wr_count_d};
            end else if (mem_accept) begin
                mem_wr_o <= 1'b0;
            end
            if (mem_accept) begin
                wr_count_q <= wr_count_q + 9'h001;
            end
        end
    end

    // ======================================================================
    // boot memory select pin
    // ======================================================================
    // driven only in eprom mode by the bus owner; low while the kernel loads,
    // released high afterwards, and floated on request
    assign boot_memory_select_oe_o = mode_valid_q && m_eprom
                                     && bus_owner_i && !select_tristate_i;
    assign boot_memory_select_n_o = !(loading && m_eprom);

    // ======================================================================
    // status outputs
    // ======================================================================
    assign boot_mode_o = mode_q;
    assign mode_valid_o = mode_valid_q;
    assign dma_channel_o = channel;
    assign link_buffer_o = bml_pkg::LINK_BOOT_BUFFER;
    assign dma_count_o = bml_pkg::BOOT_WORDS - wr_count_q;
    assign dma_active_o = loading;
    assign external_port_dma_done_irq_o = irq_q;
    assign exec_start_o = exec_q;
    assign exec_pc_o = pc_q;

endmodule : bml_loader

// >>> test/bml_loader_properties.sv
// concurrent checks on the ports of the boot mode select loader
`timescale 1ns/1ps
module bml_loader_properties (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic bus_owner_i,
    input wire logic select_tristate_i,
    input wire logic mem_ready_i,
    input wire logic ext_ready_o,
    input wire logic link_ready_o,
    input wire logic spi_rx_ready_o,
    input wire logic boot_memory_select_n_o,
    input wire logic boot_memory_select_oe_o,
    input wire logic mem_wr_o,
    input wire logic [19:0] mem_addr_o,
    input wire logic [47:0] mem_data_o,
    input wire logic [2:0] boot_mode_o,
    input wire logic mode_valid_o,
    input wire logic [3:0] dma_channel_o,
    input wire logic [2:0] link_buffer_o,
    input wire logic dma_active_o,
    input wire logic external_port_dma_done_irq_o,
    input wire logic exec_start_o,
    input wire logic [23:0] exec_pc_o
);
    // ======================================================================
    // properties
    // ======================================================================
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // a ready outside its own mode would let a foreign stream into memory
    AST_EXT_READY: assert property (ext_ready_o |-> mode_valid_o && (boot_mode_o == bml_pkg::BML_MODE_EPROM ||
        boot_mode_o == bml_pkg::BML_MODE_HOST)) else $error("external ready outside eprom or host mode");
    AST_LINK_READY: assert property (link_ready_o |-> boot_mode_o == bml_pkg::BML_MODE_LINK)
        else $error("link ready outside link mode");
    AST_SPI_READY: assert property (spi_rx_ready_o |-> boot_mode_o == bml_pkg::BML_MODE_SPI)
        else $error("spi ready outside spi mode");
    AST_CHANNEL: assert property (mode_valid_o && boot_mode_o != bml_pkg::BML_MODE_NOBOOT |-> dma_channel_o ==
        (boot_mode_o == bml_pkg::BML_MODE_SPI ? 4'h8 : boot_mode_o == bml_pkg::BML_MODE_LINK ? 4'h4 : 4'ha))
        else $error("dma channel does not match mode");
    AST_LINK_BUF: assert property (link_buffer_o == 3'h4) else $error("link buffer is not four");
    AST_OE: assert property (boot_memory_select_oe_o == (mode_valid_o && boot_mode_o == bml_pkg::BML_MODE_EPROM &&
        bus_owner_i && !select_tristate_i)) else $error("select output enable wrong");
    AST_SEL_LOW: assert property (dma_active_o && boot_mode_o == bml_pkg::BML_MODE_EPROM |->
        !boot_memory_select_n_o) else $error("select not low during eprom load");
    AST_MODE_HOLD: assert property (mode_valid_o && $past(mode_valid_o) |-> $stable(boot_mode_o))
        else $error("mode changed after latch");
    AST_MEM_HOLD: assert property (mem_wr_o && !mem_ready_i |=> mem_wr_o && $stable(mem_addr_o) &&
        $stable(mem_data_o)) else $error("write request dropped or changed");
    AST_ADDR_STEP: assert property ((mem_wr_o && mem_ready_i) ##1 mem_wr_o |->
        mem_addr_o == $past(mem_addr_o) + 20'h1) else $error("write address did not step by one");
    AST_IRQ_PULSE: assert property (external_port_dma_done_irq_o |=> !external_port_dma_done_irq_o)
        else $error("done interrupt longer than one cycle");
    AST_DONE: assert property (external_port_dma_done_irq_o |-> exec_start_o &&
        exec_pc_o == bml_pkg::BOOT_VECTOR && !dma_active_o) else $error("completion sequence wrong");
    AST_NOBOOT: assert property (boot_mode_o == bml_pkg::BML_MODE_NOBOOT && exec_start_o |->
        exec_pc_o == bml_pkg::NOBOOT_PC && !dma_active_o) else $error("no-boot start wrong");
    // main scenarios reached
    CV_DONE: cover property (external_port_dma_done_irq_o);
    CV_STALL: cover property (mem_wr_o && !mem_ready_i);
    CV_NOBOOT: cover property (exec_start_o && boot_mode_o == bml_pkg::BML_MODE_NOBOOT);
endmodule : bml_loader_properties

bind bml_loader bml_loader_properties i_props (.*);

// >>> test/bml_src_model.sv
// boot data source standing in for eprom, host, link or spi sender
`timescale 1ns/1ps
module bml_src_model (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic [4:0] w_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [15:0] data_o
);
    logic [15:0] n_q;
    logic ph_q;
    // chunk width 8 or 16 for host, 4 for link
    wire logic [15:0] mask_w = 16'hffff >> (5'h10 - w_i);
    // idle data is the inverse so a stale value never looks valid
    assign data_o = valid_o ? (n_q & mask_w) : ~(n_q & mask_w);
    // valid held until taken; slow mode withholds new chunks every other cycle
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            n_q <= 16'h0;
            ph_q <= 1'b0;
            valid_o <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            if (valid_o && ready_i) n_q <= n_q + 16'h1;
            if (!valid_o || ready_i) valid_o <= en_i && (!slow_i || ph_q);
        end
    end
endmodule : bml_src_model

// >>> test/bml_loader_test.sv
// self-checking bench for the boot mode select loader
`timescale 1ns/1ps
module bml_loader_test;
    logic mclk = 1'b0, nrst = 1'b0, estrap = 1'b0, lstrap = 1'b0, sel_ext = 1'b1, h16 = 1'b0;
    logic owner = 1'b1, tri_sel = 1'b0, mem_ready = 1'b0, src_en = 1'b0, src_slow = 1'b0;
    logic [4:0] src_w = 5'h08;
    logic src_valid, ext_ready, link_ready, spi_ready, sel_n_o, sel_oe, mem_wr, mode_valid, dma_active, irq, start_o;
    logic [15:0] src_data;
    logic [19:0] mem_addr;
    logic [47:0] mem_data;
    logic [2:0] mode, lbuf;
    logic [3:0] chan;
    logic [8:0] count;
    logic [23:0] pc;
    int fail_count = 0, cmp_count = 0;
    // pin level: driven by the device when enabled, else the board level
    wire logic sel_pin = sel_oe ? sel_n_o : sel_ext;

    always #50 mclk = ~mclk;

    bml_src_model i_src (.mclk_i(mclk), .nrst_i(nrst), .en_i(src_en), .slow_i(src_slow), .w_i(src_w),
        .ready_i(ext_ready | link_ready | spi_ready), .valid_o(src_valid), .data_o(src_data));
    // all three streams fed at once so a wrong ready shows up as refused data
    bml_loader i_dut (.mclk_i(mclk), .nrst_i(nrst), .eprom_boot_strap_i(estrap), .link_boot_strap_i(lstrap),
        .host_bus16_i(h16), .boot_memory_select_n_i(sel_pin), .boot_memory_select_n_o(sel_n_o),
        .boot_memory_select_oe_o(sel_oe), .bus_owner_i(owner), .select_tristate_i(tri_sel),
        .ext_data_i(src_data), .ext_valid_i(src_valid), .ext_ready_o(ext_ready), .link_data_i(src_data[3:0]),
        .link_valid_i(src_valid), .link_ready_o(link_ready), .spi_receive_buffer_i(src_data),
        .spi_rx_valid_i(src_valid), .spi_rx_ready_o(spi_ready), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
        .mem_data_o(mem_data), .mem_ready_i(mem_ready), .boot_mode_o(mode), .mode_valid_o(mode_valid),
        .dma_channel_o(chan), .link_buffer_o(lbuf), .dma_count_o(count), .dma_active_o(dma_active),
        .external_port_dma_done_irq_o(irq), .exec_start_o(start_o), .exec_pc_o(pc));

    // ======================================================================
    // shared tasks
    // ======================================================================
    task automatic check(input string nm, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic start(input logic e, l, s, h, input logic [2:0] md, input logic [3:0] ch);
        @(negedge mclk);
        {estrap, lstrap, sel_ext, h16, nrst, src_en, mem_ready} = {e, l, s, h, 3'h0};
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        for (int c = 0; c < 10 && mode_valid !== 1'b1; c++) @(negedge mclk);
        check("mode", 48'(md), 48'(mode));
        if (md != bml_pkg::BML_MODE_NOBOOT) check("channel", 48'(ch), 48'(chan));
        check("link buffer", 48'h4, 48'(lbuf));
    endtask : start

    // streams 256 words, memory stalls when slow, then checks completion
    task automatic load(input logic [4:0] w, input int cpw, input logic slow);
        int i;
        logic [47:0] ew;
        logic [15:0] m;
        m = 16'hffff >> (5'h10 - w);
        i = 0;
        check("count", 48'h100, 48'(count));
        {src_w, src_slow, src_en} = {w, slow, 1'b1};
        for (int c = 0; c < 20000 && i < 256; c++) begin
            @(negedge mclk);
            mem_ready = !slow || (c % 3 != 0);
            if (mem_wr === 1'b1 && mem_ready) begin
                ew = '0;
                for (int k = 0; k < cpw; k++) ew |= 48'((i * cpw + k) & m) << (k * w);
                check("addr", 48'(20'h40000 + 20'(i)), 48'(mem_addr));
                check("data", ew, mem_data);
                i++;
            end
        end
        check("words", 48'h100, 48'(i));
        for (int c = 0; c < 10 && irq !== 1'b1; c++) @(negedge mclk);
        check("irq", 48'h1, 48'(irq));
        check("exec", 48'h1, 48'(start_o));
        check("pc", 48'(bml_pkg::BOOT_VECTOR), 48'(pc));
        check("active", 48'h0, 48'(dma_active));
        check("count end", 48'h0, 48'(count));
        check("select", 48'h1, 48'(sel_n_o));
        @(negedge mclk);
        check("irq end", 48'h0, 48'(irq));
        check("pc hold", 48'(bml_pkg::BOOT_VECTOR), 48'(pc));
        src_en = 1'b0;
    endtask : load

    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic test_eprom();
        start(1'b1, 1'b1, 1'b0, 1'b0, bml_pkg::BML_MODE_EPROM, 4'ha);
        check("oe", 48'h1, 48'(sel_oe));
        check("sel low", 48'h0, 48'(sel_n_o));
        tri_sel = 1'b1;
        @(negedge mclk);
        check("oe tristate", 48'h0, 48'(sel_oe));
        {tri_sel, owner} = 2'b00;
        @(negedge mclk);
        check("oe owner", 48'h0, 48'(sel_oe));
        owner = 1'b1;
        load(5'h08, 6, 1'b1);
        check("oe after", 48'h1, 48'(sel_oe));
    endtask : test_eprom

    task automatic test_streams();
        start(1'b0, 1'b0, 1'b1, 1'b0, bml_pkg::BML_MODE_HOST, 4'ha);
        check("oe host", 48'h0, 48'(sel_oe));
        load(5'h08, 6, 1'b1);
        start(1'b0, 1'b0, 1'b1, 1'b1, bml_pkg::BML_MODE_HOST, 4'ha);
        load(5'h10, 3, 1'b0);
        start(1'b0, 1'b1, 1'b1, 1'b0, bml_pkg::BML_MODE_LINK, 4'h4);
        load(5'h04, 12, 1'b0);
        start(1'b0, 1'b1, 1'b0, 1'b0, bml_pkg::BML_MODE_SPI, 4'h8);
        load(5'h10, 3, 1'b1);
    endtask : test_streams

    task automatic test_noboot();
        start(1'b0, 1'b0, 1'b0, 1'b0, bml_pkg::BML_MODE_NOBOOT, 4'h0);
        for (int c = 0; c < 5 && start_o !== 1'b1; c++) @(negedge mclk);
        check("noboot exec", 48'h1, 48'(start_o));
        check("noboot pc", 48'(bml_pkg::NOBOOT_PC), 48'(pc));
        {estrap, src_en, mem_ready} = 3'h7;
        repeat (10) @(negedge mclk);
        check("mode hold", 48'(bml_pkg::BML_MODE_NOBOOT), 48'(mode));
        check("no write", 48'h0, 48'({mem_wr, ext_ready, dma_active}));
    endtask : test_noboot

    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        test_eprom();
        test_streams();
        test_noboot();
        end_sim();
    end

    // watchdog well beyond the roughly 12000 cycles the loads take
    initial begin
        #6_000_000;
        fail_count++;
        end_sim();
    end
endmodule : bml_loader_test
